// File: shared/dpcg_regs.vh
`ifndef DPCG_REGS_VH
`define DPCG_REGS_VH
// ==========================================================
// field widths and timing
`define DPCG_CW 12
`define DPCG_NSYNC 7
`define DPCG_NASYNC 7
`define DPCG_PWM_W 8
// embedded sync reference words, timing reference header
`define DPCG_EAV_PRE0 8'hff
`define DPCG_EAV_PRE1 8'h00
`define DPCG_EAV_PRE2 8'h00
// status word: bit6 field, bit5 vblank, bit4 end of line
`define DPCG_XY_SAV 8'h80
`define DPCG_XY_EAV 8'h90
`define DPCG_XY_VBIT 8'h20
// async access length in half cycles
`define DPCG_ACC_LEN_RST 8'h08
`endif

// File: logic/dpcg_top.v
`timescale 1ns/1ps
`include "dpcg_regs.vh"
// ==========================================================
// Contract
// - programmable mapping of colour and control lines
// - dedicated pixel clock output
// - seven general synchronous control outputs
// - data enable strobe available
// - extra strobes with independent timing
// - extra data synchronous outputs, programmable
// - embedded sync codes in 8-bit mode
// - embedded mode sends only the 8-bit stream, never async words
// - separate sync and async output groups
// - sync controls periodic, fixed waveform
// - linked counters make clock-aligned start points
// - sync set/clear offsets at half-clock resolution
// - async controls follow per-word flags
// - two chip selects for two displays
// - second select may carry pwm
// - seven general async outputs
// - async generators independent of sync ones
// - new async word gives fresh start point
// - async set/clear offsets, half-clock resolution
// - frame sync spans at least one line sync
// - data fixed to start point, whole cycles
module dpcg_top #(
  parameter CW = `DPCG_CW,
  parameter NS = `DPCG_NSYNC,
  parameter NA = `DPCG_NASYNC
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // configuration
  input wire enable,
  input wire embedded_mode,
  input wire [CW-1:0] line_len,
  input wire [CW-1:0] frame_lines,
  input wire [CW-1:0] act_x_start,
  input wire [CW-1:0] act_x_end,
  input wire [CW-1:0] act_y_start,
  input wire [CW-1:0] act_y_end,
  input wire [NS*CW-1:0] sync_set,
  input wire [NS*CW-1:0] sync_clr,
  input wire [NS-1:0] sync_frame_based,
  input wire [NS-1:0] sync_pol,
  input wire [2:0] pixel_clk_div,
  input wire pixel_clk_pol,
  input wire [NA*8-1:0] async_set,
  input wire [NA*8-1:0] async_clr,
  input wire [NA-1:0] async_pol,
  input wire [1:0] select_pol,
  input wire select_b_pwm_mode,
  input wire [7:0] pwm_duty,
  input wire [7:0] async_acc_len,
  input wire [23:0] bit_map_sel,
  // pixel stream
  input wire [23:0] pixel_in,
  output reg pixel_req,
  // async word request
  input wire async_valid,
  input wire [23:0] async_word,
  input wire [NA-1:0] async_flags,
  input wire async_dest,
  output reg async_ready,
  // panel frame sync input
  input wire sync_ctrl_in_1,
  output reg tear_sync_seen,
  // panel pins
  output reg [23:0] pixel_data,
  output reg panel_clock_out,
  output reg [NS-1:0] sync_ctrl_out,
  output reg [NA-1:0] async_ctrl_out,
  output reg display_select_a,
  output reg display_select_b,
  output reg data_enable_strobe
);
  // ========================================================
  // half-cycle phase: each clock has an early and late half
  reg [CW-1:0] hcnt;
  reg [CW-1:0] vcnt;
  reg [2:0] pdiv;
  reg pclk_tick;
  reg in_s1;
  reg in_s2;
  reg in_s3;
  wire line_end = (hcnt == line_len);
  wire frame_end = line_end && (vcnt == frame_lines);
  wire act_x = (hcnt >= act_x_start) && (hcnt < act_x_end);
  wire act_y = (vcnt >= act_y_start) && (vcnt < act_y_end);

  // linked line and frame counters; the line wrap is the start point
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hcnt <= {CW{1'b0}};
      vcnt <= {CW{1'b0}};
    end else if (!enable) begin
      hcnt <= {CW{1'b0}};
      vcnt <= {CW{1'b0}};
    end else if (line_end) begin
      hcnt <= {CW{1'b0}};
      vcnt <= frame_end ? {CW{1'b0}} : vcnt + 1'b1;
    end else begin
      hcnt <= hcnt + 1'b1;
    end
  end

  // pixel clock divider; whole clock periods only
  // the tick is a one-clock enable, so no second clock domain exists
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pdiv <= 3'h0;
      pclk_tick <= 1'b0;
    end else begin
      pclk_tick <= 1'b0;
      if (!enable || pdiv == pixel_clk_div) begin
        pdiv <= 3'h0;
        pclk_tick <= enable;
      end else begin
        pdiv <= pdiv + 1'b1;
      end
    end
  end

  // panel frame sync, synchronised; only the second stage is compared
  // the third stage just remembers the last level for edge finding
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      in_s3 <= 1'b0;
      tear_sync_seen <= 1'b0;
    end else begin
      in_s1 <= sync_ctrl_in_1;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      tear_sync_seen <= in_s2 && !in_s3;
    end
  end

  // ========================================================
  // synchronous generators: set and clear are in half cycles,
  // bit 0 chooses the late half; frame-based ones count lines
  wire [NS-1:0] sync_lvl;
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_sync
      wire [CW-1:0] s = sync_set[g*CW +: CW];
      wire [CW-1:0] c = sync_clr[g*CW +: CW];
      wire [CW-1:0] pos = sync_frame_based[g] ?
        {vcnt[CW-2:0], 1'b0} : {hcnt[CW-2:0], 1'b0};
      // level during this clock's early and late halves
      wire early = (pos >= s) && (pos < c);
      wire late = ({pos[CW-1:1], 1'b1} >= s) &&
        ({pos[CW-1:1], 1'b1} < c);
      // a late-half edge is seen one half earlier; using the late
      // value puts the edge on that clock, with no second clock domain
      assign sync_lvl[g] = enable && (s[0] ? late : early);
    end
  endgenerate

  // ========================================================
  // embedded sync sequencer for the 8-bit stream
  reg [1:0] ref_idx;
  reg [7:0] emb_byte;
  // header starts four clocks before the window; the sum is one bit
  // wider so an early window start cannot take a false match from a wrapped sum
  wire [CW:0] sav_mark = {1'b0, hcnt} + {{(CW-2){1'b0}}, 3'd4};
  wire near_sav = (sav_mark == {1'b0, act_x_start});
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_idx <= 2'h0;
      emb_byte <= 8'h10;
    end else if (!enable) begin
      // a held raster sends plain fill, never a stray header
      ref_idx <= 2'h0;
      emb_byte <= 8'h10;
    end else if (!act_x) begin
      // reference header emitted in the four clocks before and
      // after the active region; blanking carries no ancillary data
      if ((hcnt == act_x_end) || near_sav || ref_idx != 2'h0) begin
        ref_idx <= ref_idx + 1'b1;
        case (ref_idx)
          2'h0: emb_byte <= `DPCG_EAV_PRE0;
          2'h1: emb_byte <= `DPCG_EAV_PRE1;
          2'h2: emb_byte <= `DPCG_EAV_PRE2;
          default: emb_byte <= (near_sav || hcnt < act_x_start ?
            `DPCG_XY_SAV : `DPCG_XY_EAV) |
            (act_y ? 8'h00 : `DPCG_XY_VBIT);
        endcase
      end else begin
        emb_byte <= 8'h10;
      end
    end else begin
      ref_idx <= 2'h0;
      emb_byte <= act_y ? pixel_in[7:0] : 8'h10;
    end
  end

  // ========================================================
  // async generator: own start point per word, independent of
  // the raster counters
  reg busy;
  reg [7:0] acnt;
  reg [23:0] aword;
  reg [NA-1:0] aflags;
  reg adest;
  wire [NA-1:0] async_lvl;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      acnt <= 8'h00;
      aword <= 24'h00_0000;
      aflags <= {NA{1'b0}};
      adest <= 1'b0;
      async_ready <= 1'b0;
    end else begin
      async_ready <= !busy && !async_valid;
      if (!busy && async_valid && async_ready) begin
        busy <= 1'b1;
        acnt <= 8'h00;
        aword <= async_word;
        aflags <= async_flags;
        adest <= async_dest;
      end else if (busy) begin
        // two half cycles per clock; length kept even so the
        // access spans whole clock periods
        if (acnt + 8'h02 >= {async_acc_len[7:1], 1'b0}) begin
          busy <= 1'b0;
        end
        acnt <= acnt + 8'h02;
      end
    end
  end

  // async pin levels from the set and clear offsets of this access
  generate
    for (g = 0; g < NA; g = g + 1) begin : g_async
      wire [7:0] s = async_set[g*8 +: 8];
      wire [7:0] c = async_clr[g*8 +: 8];
      wire [7:0] p = s[0] ? {acnt[7:1], 1'b1} : acnt;
      assign async_lvl[g] = busy && aflags[g] &&
        (p >= s) && (p < c);
    end
  endgenerate

  // pwm for the second select in its alternate function
  // free running; a duty of zero keeps the select low throughout
  reg [7:0] pwm_cnt;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt <= 8'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 1'b1;
    end
  end

  // ========================================================
  // data lane mapping: a set bit makes a lane take its mirror's bit
  // lanes choose one by one, so any mirrored subset can be chosen
  wire [23:0] pix_mapped;
  generate
    for (g = 0; g < 24; g = g + 1) begin : g_map
      assign pix_mapped[g] = bit_map_sel[g] ?
        pixel_in[23-g] : pixel_in[g];
    end
  endgenerate

  // window strobes; the panel only takes data while the strobe is high
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pixel_req <= 1'b0;
      data_enable_strobe <= 1'b0;
    end else begin
      pixel_req <= enable && act_x && act_y;
      data_enable_strobe <= enable && act_x && act_y;
    end
  end

  // pixel clock toggles on divider ticks and rests at its idle level
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      panel_clock_out <= 1'b0;
    end else if (!enable) begin
      panel_clock_out <= pixel_clk_pol;
    end else if (pclk_tick) begin
      panel_clock_out <= ~panel_clock_out;
    end
  end

  // sync group; pin 1 line sync, pin 2 frame sync by mapping.
  // frame sync set and clear in lines spans a line sync
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_ctrl_out <= {NS{1'b0}};
    end else begin
      sync_ctrl_out <= sync_lvl ^ sync_pol;
    end
  end

  // async group kept on its own pins, polarity applied last
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      async_ctrl_out <= {NA{1'b0}};
    end else begin
      async_ctrl_out <= async_lvl ^ async_pol;
    end
  end

  // chip selects follow the access; the second may carry the pwm
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      display_select_a <= 1'b0;
      display_select_b <= 1'b0;
    end else begin
      display_select_a <= (busy && !adest) ^ select_pol[0];
      if (select_b_pwm_mode) begin
        display_select_b <= (pwm_cnt < pwm_duty);
      end else begin
        display_select_b <= (busy && adest) ^ select_pol[1];
      end
    end
  end

  // data lanes: embedded stream, async word or mapped pixel; the
  // data never moves against the start point
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pixel_data <= 24'h00_0000;
    end else if (embedded_mode) begin
      pixel_data <= {16'h0000, emb_byte};
    end else if (busy) begin
      pixel_data <= aword;
    end else if (act_x && act_y) begin
      pixel_data <= pix_mapped;
    end else begin
      pixel_data <= 24'h00_0000;
    end
  end
endmodule // dpcg_top

// File: sim/dpcg_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module dpcg_chk #(parameter CW = 12, NS = 7, NA = 7) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // configuration and requests
  input wire enable,
  input wire embedded_mode,
  input wire [2:0] pixel_clk_div,
  input wire async_valid,
  input wire [23:0] async_word,
  input wire [NA-1:0] async_flags,
  input wire async_dest,
  input wire [NA-1:0] async_pol,
  input wire [1:0] select_pol,
  input wire sync_ctrl_in_1,
  // design outputs
  input wire async_ready,
  input wire tear_sync_seen,
  input wire [23:0] pixel_data,
  input wire panel_clock_out,
  input wire [NA-1:0] async_ctrl_out,
  input wire display_select_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire take = async_valid && async_ready;
  reg pc;
  reg ht;
  reg [3:0] hc;
  // clocks since the last panel clock edge; armed only while enabled
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= 1'b0;
      ht <= 1'b0;
      hc <= 4'h0;
    end else begin
      pc <= panel_clock_out;
      if (pc != panel_clock_out) hc <= 4'h0;
      else hc <= hc + 4'h1;
      if (!enable) ht <= 1'b0;
      else if (pc != panel_clock_out) ht <= 1'b1;
    end
  end
  pclk_rate_a: assert property (ht && enable && pc != panel_clock_out
    |-> hc == {1'b0, pixel_clk_div}) else $error("panel clock rate");
  ready_gap_a: assert property (async_ready |-> !$past(async_valid))
    else $error("ready without idle gap");
  take_busy_a: assert property (take |=> !async_ready)
    else $error("ready during access");
  select_a_a: assert property (take && !async_dest
    |-> ##2 display_select_a != select_pol[0]) else $error("select a");
  word_out_a: assert property (take
    |-> ##2 pixel_data == $past(async_word, 2)) else $error("word");
  flags_out_a: assert property (take
    |-> ##2 async_ctrl_out == ($past(async_flags, 2) ^ async_pol))
    else $error("async pins");
  embed_hi_a: assert property (embedded_mode && $past(embedded_mode)
    |-> pixel_data[23:8] == 16'h0000) else $error("upper lanes");
  embed_hdr_a: assert property (embedded_mode
    && pixel_data[7:0] == 8'hff |=> pixel_data[7:0] == 8'h00
    ##1 pixel_data[7:0] == 8'h00 ##1 (pixel_data[7:0] & 8'hcf) == 8'h80)
    else $error("header");
  tear_pulse_a: assert property (tear_sync_seen |=> !tear_sync_seen)
    else $error("tear pulse long");
  tear_rise_a: assert property ($rose(sync_ctrl_in_1)
    |-> ##[1:4] tear_sync_seen) else $error("tear missed");
endmodule // dpcg_chk

// File: sim/dpcg_panel.sv
`timescale 1ns/1ps
// ==========================================================
// panel model
module dpcg_panel (
  // clock and pins
  input wire clk,
  input wire go,
  input wire de,
  input wire [23:0] pix,
  // frame sync out, captures
  output reg fs_out,
  output reg [23:0] last_pix,
  output reg [15:0] n_pix
);
  // own 160 ns clock, off phase; still while go is low
  initial begin
    fs_out = 1'b0;
    n_pix = 16'h0000;
    last_pix = 24'h00_0000;
    #3;
    forever #80 fs_out = go ? ~fs_out : 1'b0;
  end
  // data taken only while the strobe is up
  always @(posedge clk) begin
    if (de) begin
      last_pix <= pix;
      n_pix <= n_pix + 16'h0001;
    end
  end
endmodule // dpcg_panel

// File: sim/dpcg_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
// ==========================================================
// bench top
module dpcg_top_tb;
  logic clk, reset_n, enable, embedded_mode, pixel_clk_pol, go;
  logic [11:0] line_len, frame_lines, act_x_start, act_x_end;
  logic [11:0] act_y_start, act_y_end;
  logic [83:0] sync_set, sync_clr;
  logic [6:0] sync_frame_based, sync_pol, async_pol, async_flags;
  logic [55:0] async_set, async_clr;
  logic [2:0] pixel_clk_div;
  logic [1:0] select_pol;
  logic select_b_pwm_mode, async_valid, async_dest, sync_ctrl_in_1;
  logic [7:0] pwm_duty, async_acc_len;
  logic [23:0] bit_map_sel, pixel_in, async_word, pixel_data, last_pix;
  logic pixel_req, async_ready, tear_sync_seen, panel_clock_out;
  logic display_select_a, display_select_b, data_enable_strobe;
  logic [6:0] sync_ctrl_out, async_ctrl_out;
  logic [15:0] n_pix, k, a;
  logic tk;
  int errors, check_count;
  wire [4:0] mon = {sync_ctrl_out[2], pixel_req, tear_sync_seen,
    display_select_b, sync_ctrl_out[1]};
  dpcg_top dut_u (.*);
  dpcg_panel pm_u (.clk(clk), .go(go), .de(data_enable_strobe),
    .pix(pixel_data), .fs_out(sync_ctrl_in_1), .last_pix(last_pix),
    .n_pix(n_pix));
  always #5 clk = ~clk;
  // verdict; both the tests and the watchdog end here
  task report_and_stop;
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // high cycles of one monitored pin over n clocks
  task cnt(input [2:0] s, input [15:0] n, input [15:0] e);
    k = 16'h0000;
    repeat (n) begin @(posedge clk); #1 k = k + mon[s]; end
    `CHK(k, e)
  endtask
  // one async word; ready looked at mid cycle to avoid an edge race
  task acc(input d, input [6:0] f, input [23:0] w, input [7:0] len);
    @(posedge clk);
    #1 {async_dest, async_flags, async_word, async_acc_len} = {d, f, w, len};
    async_valid = 1'b1;
    tk = 1'b0;
    for (int i = 0; i < 20 && !tk; i++) begin
      @(negedge clk) tk = async_ready;
      @(posedge clk);
    end
    #1 async_valid = 1'b0;
    k = 16'h0000;
    repeat (12) begin
      @(posedge clk);
      #1 k = k + (d ? display_select_b : display_select_a);
    end
    `CHK(k, {8'h00, len >> 1})
  endtask
  initial begin
    #100000 errors++;
    report_and_stop;
  end
  initial begin
    {clk, reset_n, go, enable, embedded_mode, pixel_clk_pol} = '0;
    {sync_frame_based, sync_pol, async_pol, select_pol, pwm_duty} = '0;
    {select_b_pwm_mode, bit_map_sel, async_valid, async_dest} = '0;
    {async_flags, async_word, async_set, sync_set} = '0;
    {line_len, frame_lines} = {12'h00f, 12'h007};
    sync_frame_based = 7'h04;
    {act_x_start, act_x_end} = {12'h004, 12'h00c};
    {act_y_start, act_y_end} = {12'h002, 12'h006};
    sync_clr = {7{12'h00c}};
    async_clr = {7{8'h10}};
    {pixel_clk_div, async_acc_len, pixel_in} = {3'h3, 8'h08, 24'hc0_0001};
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    @(posedge clk) #1 enable = 1'b1;
    repeat (200) @(posedge clk);
    #1 a = n_pix;
    cnt(0, 128, 16'h0030);
    `CHK(n_pix - a, 16'h0020)
    `CHK(last_pix, 24'hc0_0001)
    cnt(3, 128, 16'h0020);
    cnt(4, 128, 16'h0060);
    sync_pol = 7'h02;
    bit_map_sel = 24'hff_ffff;
    repeat (150) @(posedge clk);
    cnt(0, 128, 16'h0050);
    `CHK(last_pix, 24'h80_0003)
    {enable, bit_map_sel, async_pol} = {1'b0, 24'h00_0000, 7'h0f};
    repeat (4) @(posedge clk);
    acc(0, 7'h55, 24'ha5_5a01, 8'h08);
    acc(1, 7'h2a, 24'h3c_c3f0, 8'h06);
    acc(0, 7'h7f, 24'h0f_f00f, 8'h02);
    {select_b_pwm_mode, pwm_duty} = {1'b1, 8'h40};
    repeat (4) @(posedge clk);
    cnt(1, 256, 16'h0040);
    #1 {select_b_pwm_mode, go} = 2'b01;
    repeat (20) @(posedge clk);
    cnt(2, 64, 16'h0004);
    #1 {go, embedded_mode, enable, pixel_in} = {3'b011, 24'h00_005a};
    repeat (300) @(posedge clk);
    #1 reset_n = 1'b0;
    embedded_mode = 1'b0;
    @(posedge clk) #1;
    k = {display_select_a, display_select_b, sync_ctrl_out, async_ctrl_out};
    `CHK(k, 16'h0000)
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (20) @(posedge clk);
    report_and_stop;
  end
endmodule // dpcg_top_tb
bind dpcg_top dpcg_chk #(.CW(CW), .NS(NS), .NA(NA)) chk_u (.*);
